// *** inc/vsim_pkg.sv ***
package vsim_pkg;
  // =====================================================
  // data path widths
  localparam int VSIM_DATA_W = 10;
  localparam int VSIM_PIN_W = 6;
  localparam int VSIM_CTL_W = 8;
  // =====================================================
  // register port map (word index on i_addr)
  localparam int VSIM_ADDR_W = 4;
  localparam logic [3:0] VSIM_ADDR_CTRL = 4'h0;
  localparam logic [3:0] VSIM_ADDR_STATUS = 4'h1;
  localparam logic [1:0] VSIM_CTRL_RST = 2'h0;
  localparam int VSIM_CTRL_STANDBY_BIT = 0;
  localparam int VSIM_CTRL_SDO_OFF_BIT = 1;
  localparam int VSIM_STAT_ASI_ERR_BIT = 6;
  localparam int VSIM_STAT_BAD_CFG_BIT = 7;
  // =====================================================
  // positions of the static pins and soft control bits inside the control vector
  localparam int VSIM_PIN_STANDBY = 0;
  localparam int VSIM_PIN_SDO_EN = 1;
  localparam int VSIM_PIN_RATE = 2;
  localparam int VSIM_PIN_WIDTH = 3;
  localparam int VSIM_PIN_STDPROC = 4;
  localparam int VSIM_PIN_ASI = 5;
  localparam int VSIM_SOFT_STANDBY = 6;
  localparam int VSIM_SOFT_SDO_OFF = 7;
  // =====================================================
  // line rate codes on o_rate_sd
  localparam logic VSIM_RATE_HD = 1'b0;
  localparam logic VSIM_RATE_SD = 1'b1;
  // =====================================================
  // self-synchronising scrambler, x^9 + x^4 + 1
  localparam int VSIM_SCR_LEN = 9;
  localparam int VSIM_SCR_TAP_A = 8;
  localparam int VSIM_SCR_TAP_B = 3;
  localparam logic [8:0] VSIM_SCR_SEED = 9'h000;
  // =====================================================
  // what the upper half-bus carries
  typedef enum logic [2:0] {
    VSIM_ROUTE_IDLE = 3'b000,
    VSIM_ROUTE_CHROMA = 3'b001,
    VSIM_ROUTE_RAW = 3'b010,
    VSIM_ROUTE_LOW = 3'b011,
    VSIM_ROUTE_BAD = 3'b100
  } vsim_route_t;
endpackage

// *** inc/vsim_scr_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// carries one word between the routing logic and the scrambler
interface vsim_scr_if #(parameter int WIDTH = 10);
  logic enable;
  logic advance;
  logic [WIDTH-1:0] word_in;
  logic [WIDTH-1:0] word_out;
  modport user (output enable, output advance, output word_in, input word_out);
  modport core (input enable, input advance, input word_in, output word_out);
endinterface
`default_nettype wire

// *** hdl/vsim_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module vsim_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("vsim_sync: WIDTH must be at least 1");
    end
  endgenerate

  // =====================================================
  // two stages; only the second stage reads the first
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule
`default_nettype wire

// *** hdl/vsim_scrambler.sv ***
`timescale 1ns/1ps
`default_nettype none
module vsim_scrambler
  import vsim_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  vsim_scr_if.core scr
);
  logic [VSIM_SCR_LEN-1:0] state_reg;
  logic [VSIM_SCR_LEN-1:0] state_next;
  logic [$bits(scr.word_in)-1:0] word;

  // =====================================================
  // bits go out lsb first; each scrambled bit feeds the history
  always_comb begin
    state_next = state_reg;
    word = scr.word_in;
    if (scr.enable) begin
      for (int i = 0; i < $bits(scr.word_in); i++) begin
        word[i] = scr.word_in[i] ^ state_next[VSIM_SCR_TAP_A] ^ state_next[VSIM_SCR_TAP_B];
        state_next = {state_next[VSIM_SCR_LEN-2:0], word[i]};
      end
    end
    // history only moves on words that really go out
    if (!scr.advance) begin
      state_next = state_reg;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= VSIM_SCR_SEED;
    end else begin
      state_reg <= state_next;
    end
  end

  assign scr.word_out = word;
endmodule
`default_nettype wire

// *** hdl/vsim_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Contract
// - a high standby pin puts the block in standby and stops transmission.
// - a low serial output enable floats both serial outputs, a high one drives them.
// - a low rate select sets high-definition operation at the 1.485 Gb/s family of rates.
// - a high rate select sets standard-definition operation at 270 Mb/s only.
// - the upper half-bus is ten bits, bit 9 msb, sampled on the parallel clock.
// - in 20-bit mode with processing on and async serial mode off the bus carries chroma.
// - in 20-bit mode with processing bypassed and async serial mode off data passes through.
// - in either 10-bit mode the upper half-bus is ignored in every processing mode.
// - processing enabled means scrambling on unless in standby, bypassed means no scrambling at all.
module vsim_top
  import vsim_pkg::*;
#(
  parameter int DATA_W = VSIM_DATA_W
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_pclk,
  input wire logic i_standby,
  input wire logic i_serial_output_enable,
  input wire logic i_rate_select,
  input wire logic i_bus_width_select,
  input wire logic i_standard_processing_enable,
  input wire logic i_async_serial_iface_mode,
  input wire logic [DATA_W-1:0] i_din,
  input wire logic [VSIM_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic [DATA_W-1:0] o_upper_data,
  output logic o_upper_valid,
  output logic [2:0] o_upper_route,
  output logic o_scramble_en,
  output logic o_rate_sd,
  output logic o_standby,
  output logic o_sdo_p,
  output logic o_sdo_n,
  output logic o_sdo_oe
);
  generate
    if (DATA_W != VSIM_DATA_W) begin : g_bad_width
      $error("vsim_top: upper half-bus must be ten bits");
    end
  endgenerate

  // =====================================================
  // parallel clock domain: pin and soft control synchronisers
  logic [1:0] ctrl_reg;
  logic [1:0] ctrl_next;
  logic [VSIM_CTL_W-1:0] ctl_raw;
  logic [VSIM_CTL_W-1:0] ctl_s;

  assign ctl_raw = {ctrl_reg[VSIM_CTRL_SDO_OFF_BIT], ctrl_reg[VSIM_CTRL_STANDBY_BIT],
                    i_async_serial_iface_mode, i_standard_processing_enable,
                    i_bus_width_select, i_rate_select, i_serial_output_enable, i_standby};

  // pins are static straps but may move at any time; two stages before use
  vsim_sync #(.WIDTH(VSIM_CTL_W)) u_ctl_sync (
    .i_clock(i_pclk),
    .i_arst_n(i_arst_n),
    .i_async(ctl_raw),
    .o_sync(ctl_s)
  );

  // =====================================================
  // parallel clock domain: routing of the upper half-bus
  vsim_scr_if #(.WIDTH(DATA_W)) scr_bus ();

  vsim_scrambler u_scr (
    .i_clock(i_pclk),
    .i_arst_n(i_arst_n),
    .scr(scr_bus)
  );

  logic [DATA_W-1:0] din_q_reg;
  logic [DATA_W-1:0] din_q_next;
  logic [DATA_W-1:0] data_reg;
  logic [DATA_W-1:0] data_next;
  vsim_route_t route_reg;
  vsim_route_t route_next;
  logic valid_reg;
  logic valid_next;
  logic scr_reg;
  logic scr_next;
  logic rate_reg;
  logic rate_next;
  logic stby_reg;
  logic stby_next;
  logic oe_reg;
  logic oe_next;
  logic tx_reg;
  logic tx_next;
  logic err_tgl_reg;
  logic err_tgl_next;
  logic bad_reg;
  logic bad_next;
  logic standby_eff;
  logic width20;
  logic asi_hit;

  // input data is already on the parallel clock, so one register suffices
  always_comb begin
    din_q_next = i_din;
    standby_eff = ctl_s[VSIM_PIN_STANDBY] | ctl_s[VSIM_SOFT_STANDBY];
    width20 = ctl_s[VSIM_PIN_WIDTH];
    route_next = VSIM_ROUTE_IDLE;
    if (standby_eff || !width20) begin
      route_next = VSIM_ROUTE_IDLE;
    end else if (!ctl_s[VSIM_PIN_ASI]) begin
      if (ctl_s[VSIM_PIN_STDPROC]) begin
        route_next = VSIM_ROUTE_CHROMA;
      end else begin
        route_next = VSIM_ROUTE_RAW;
      end
    end else if (ctl_s[VSIM_PIN_RATE] && !ctl_s[VSIM_PIN_STDPROC]) begin
      route_next = VSIM_ROUTE_LOW;
    end else begin
      // async serial mode needs SD rate and bypass; anything else is refused
      route_next = VSIM_ROUTE_BAD;
    end
    scr_bus.enable = ctl_s[VSIM_PIN_STDPROC] & ~standby_eff;
    scr_bus.advance = (route_next == VSIM_ROUTE_CHROMA);
    scr_bus.word_in = din_q_reg;
    case (route_next)
      VSIM_ROUTE_CHROMA: data_next = scr_bus.word_out;
      VSIM_ROUTE_RAW: data_next = din_q_reg;
      default: data_next = '0;
    endcase
    valid_next = (route_next == VSIM_ROUTE_CHROMA) || (route_next == VSIM_ROUTE_RAW);
    scr_next = scr_bus.enable;
    rate_next = ctl_s[VSIM_PIN_RATE] ? VSIM_RATE_SD : VSIM_RATE_HD;
    stby_next = standby_eff;
    // the source must hold the bus low here; a nonzero word is reported
    asi_hit = (route_next == VSIM_ROUTE_LOW) && (din_q_reg != '0);
    err_tgl_next = err_tgl_reg ^ asi_hit;
    bad_next = (route_next == VSIM_ROUTE_BAD);
    oe_next = ctl_s[VSIM_PIN_SDO_EN] & ~ctl_s[VSIM_SOFT_SDO_OFF] & ~standby_eff;
    // serialiser proper lies outside; the pair shows line parity of the word
    tx_next = ^data_next & oe_next;
  end

  always_ff @(posedge i_pclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      din_q_reg <= '0;
      data_reg <= '0;
      route_reg <= VSIM_ROUTE_IDLE;
      valid_reg <= 1'b0;
      scr_reg <= 1'b0;
      rate_reg <= VSIM_RATE_HD;
      stby_reg <= 1'b0;
      oe_reg <= 1'b0;
      tx_reg <= 1'b0;
      err_tgl_reg <= 1'b0;
      bad_reg <= 1'b0;
    end else begin
      din_q_reg <= din_q_next;
      data_reg <= data_next;
      route_reg <= route_next;
      valid_reg <= valid_next;
      scr_reg <= scr_next;
      rate_reg <= rate_next;
      stby_reg <= stby_next;
      oe_reg <= oe_next;
      tx_reg <= tx_next;
      err_tgl_reg <= err_tgl_next;
      bad_reg <= bad_next;
    end
  end

  assign o_upper_data = data_reg;
  assign o_upper_valid = valid_reg;
  assign o_upper_route = route_reg;
  assign o_scramble_en = scr_reg;
  assign o_rate_sd = rate_reg;
  assign o_standby = stby_reg;
  assign o_sdo_oe = oe_reg;
  assign o_sdo_p = tx_reg;
  assign o_sdo_n = ~tx_reg & oe_reg;

  // =====================================================
  // system clock domain: status crossing and register port
  logic [VSIM_CTL_W-1:0] stat_raw;
  logic [VSIM_CTL_W-1:0] stat_s;
  logic err_seen_reg;
  logic err_seen_next;
  logic asi_err_reg;
  logic asi_err_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic err_event;
  logic stat_clr;

  // pins are crossed again here rather than taken from the other domain
  assign stat_raw = {bad_reg, err_tgl_reg, i_async_serial_iface_mode,
                     i_standard_processing_enable, i_bus_width_select,
                     i_rate_select, i_serial_output_enable, i_standby};

  vsim_sync #(.WIDTH(VSIM_CTL_W)) u_stat_sync (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_async(stat_raw),
    .o_sync(stat_s)
  );

  // write-one-to-clear sticky flag; a new event wins over the clear
  always_comb begin
    err_event = stat_s[VSIM_STAT_ASI_ERR_BIT] ^ err_seen_reg;
    err_seen_next = stat_s[VSIM_STAT_ASI_ERR_BIT];
    stat_clr = i_wr && (i_addr == VSIM_ADDR_STATUS) && i_wdata[VSIM_STAT_ASI_ERR_BIT];
    asi_err_next = (asi_err_reg & ~stat_clr) | err_event;
    ctrl_next = ctrl_reg;
    if (i_wr && (i_addr == VSIM_ADDR_CTRL)) begin
      ctrl_next = i_wdata[1:0];
    end
    rdata_next = '0;
    if (i_rd) begin
      case (i_addr)
        VSIM_ADDR_CTRL: rdata_next = {30'h0000_0000, ctrl_reg};
        VSIM_ADDR_STATUS: rdata_next = {24'h00_0000, stat_s[VSIM_STAT_BAD_CFG_BIT],
                                        asi_err_reg, stat_s[VSIM_PIN_W-1:0]};
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_reg <= VSIM_CTRL_RST;
      err_seen_reg <= 1'b0;
      asi_err_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      err_seen_reg <= err_seen_next;
      asi_err_reg <= asi_err_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;

  // =====================================================
  // checks in the parallel clock domain
  property p_standby;
    @(posedge i_pclk) disable iff (!i_arst_n)
    ctl_s[VSIM_PIN_STANDBY] |=> (o_standby && !o_sdo_oe && !o_upper_valid);
  endproperty
  a_standby: assert property (p_standby) else $error("standby did not stop transmission");

  property p_sdo_off;
    @(posedge i_pclk) disable iff (!i_arst_n)
    !ctl_s[VSIM_PIN_SDO_EN] |=> !o_sdo_oe;
  endproperty
  a_sdo_off: assert property (p_sdo_off) else $error("serial output driven while disabled");

  property p_sdo_on;
    @(posedge i_pclk) disable iff (!i_arst_n)
    (ctl_s[VSIM_PIN_SDO_EN] && !ctl_s[VSIM_SOFT_SDO_OFF] && !standby_eff) |=> o_sdo_oe;
  endproperty
  a_sdo_on: assert property (p_sdo_on) else $error("serial pair idle while enabled");

  // a floated pair must not show a level on either leg
  property p_pair_idle;
    @(posedge i_pclk) disable iff (!i_arst_n)
    !o_sdo_oe |-> (!o_sdo_p && !o_sdo_n);
  endproperty
  a_pair_idle: assert property (p_pair_idle) else $error("pair active while floated");

  property p_rate_hd;
    @(posedge i_pclk) disable iff (!i_arst_n)
    !ctl_s[VSIM_PIN_RATE] |=> (o_rate_sd == VSIM_RATE_HD);
  endproperty
  a_rate_hd: assert property (p_rate_hd) else $error("HD rate not selected");

  property p_rate_sd;
    @(posedge i_pclk) disable iff (!i_arst_n)
    ctl_s[VSIM_PIN_RATE] |=> (o_rate_sd == VSIM_RATE_SD);
  endproperty
  a_rate_sd: assert property (p_rate_sd) else $error("SD rate not selected");

  property p_chroma;
    @(posedge i_pclk) disable iff (!i_arst_n)
    (width20 && !standby_eff && ctl_s[VSIM_PIN_STDPROC] && !ctl_s[VSIM_PIN_ASI])
      |=> (o_upper_route == VSIM_ROUTE_CHROMA && o_upper_valid && o_scramble_en);
  endproperty
  a_chroma: assert property (p_chroma) else $error("chroma route not taken");

  property p_raw;
    @(posedge i_pclk) disable iff (!i_arst_n)
    (width20 && !standby_eff && !ctl_s[VSIM_PIN_STDPROC] && !ctl_s[VSIM_PIN_ASI])
      |=> (o_upper_data == $past(din_q_reg) && o_upper_valid);
  endproperty
  a_raw: assert property (p_raw) else $error("raw data not passed through");

  property p_asi_low;
    @(posedge i_pclk) disable iff (!i_arst_n)
    (route_next == VSIM_ROUTE_LOW && din_q_reg != '0)
      |=> (o_upper_data == '0 && err_tgl_reg != $past(err_tgl_reg));
  endproperty
  a_asi_low: assert property (p_asi_low) else $error("async mode word not flagged");

  property p_narrow;
    @(posedge i_pclk) disable iff (!i_arst_n)
    !width20 |=> (o_upper_data == '0 && !o_upper_valid && o_upper_route == VSIM_ROUTE_IDLE);
  endproperty
  a_narrow: assert property (p_narrow) else $error("upper bus used in 10-bit mode");

  property p_bypass;
    @(posedge i_pclk) disable iff (!i_arst_n)
    !ctl_s[VSIM_PIN_STDPROC] |=> !o_scramble_en;
  endproperty
  a_bypass: assert property (p_bypass) else $error("scrambling active in bypass");

  property p_sync_delay;
    @(posedge i_pclk) disable iff (!i_arst_n)
    ##2 (ctl_s == $past(ctl_raw, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("pins not two stages late");

  // check in the system clock domain, then covers on both clocks
  property p_sticky;
    @(posedge i_clock) disable iff (!i_arst_n)
    err_event |=> asi_err_reg [*2];
  endproperty
  a_sticky: assert property (p_sticky) else $error("async error flag lost");

  c_chroma: cover property (@(posedge i_pclk) disable iff (!i_arst_n)
    o_upper_route == VSIM_ROUTE_CHROMA ##1 o_upper_route == VSIM_ROUTE_RAW);
  c_asi_err: cover property (@(posedge i_clock) disable iff (!i_arst_n)
    err_event ##1 stat_clr);
  c_standby: cover property (@(posedge i_pclk) disable iff (!i_arst_n)
    o_sdo_oe ##1 o_standby);
  c_sd_narrow: cover property (@(posedge i_pclk) disable iff (!i_arst_n)
    o_rate_sd && !width20);
  c_asi_low: cover property (@(posedge i_pclk) disable iff (!i_arst_n)
    asi_hit ##1 (o_upper_route == VSIM_ROUTE_LOW));
endmodule
`default_nettype wire

// *** verification/vsim_source.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// upstream source: drives the upper half-bus on the parallel clock
module vsim_source
  import vsim_pkg::*;
(
  input wire logic i_pclk,
  input wire logic i_arst_n,
  input wire logic [VSIM_DATA_W-1:0] i_word,
  input wire logic i_rate_select,
  input wire logic i_bus_width_select,
  input wire logic i_standard_processing_enable,
  input wire logic i_async_serial_iface_mode,
  input wire logic i_break_rule,
  output logic [VSIM_DATA_W-1:0] o_din
);
  logic [VSIM_DATA_W-1:0] din_reg;
  logic [VSIM_DATA_W-1:0] din_next;
  logic hold_low;
  // sd 20-bit async mode with bypass: the source owes an all-low bus
  assign hold_low = i_rate_select && !i_standard_processing_enable && i_async_serial_iface_mode;
  // the unused bus toggles every word so a leak into the design shows up
  always_comb begin
    din_next = i_word;
    if (!i_bus_width_select) begin
      din_next = ~din_reg;
    end else if (hold_low && !i_break_rule) begin
      // a broken source is modelled on purpose so the error path gets exercised
      din_next = '0;
    end
  end
  // launched on the parallel clock like the real source
  always_ff @(posedge i_pclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      din_reg <= '0;
    end else begin
      din_reg <= din_next;
    end
  end
  assign o_din = din_reg;
endmodule
`default_nettype wire

// *** verification/vsim_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module vsim_top_bench;
  import vsim_pkg::*;
  // =====================================================
  // stimulus and observed signals
  logic clock = 1'b0;
  logic pclk = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] pins = 6'h00;
  logic [9:0] word = 10'h000;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic brk = 1'b0;
  logic [9:0] din, up_data;
  logic [31:0] rdata;
  logic [2:0] route;
  logic up_valid, scr_en, rate_sd, standby, sdo_p, sdo_n, sdo_oe;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  // modes as {asi, proc, width, rate, sdo_en, standby}; expect {route, valid, scramble}
  localparam logic [5:0] MODES [10] = '{6'h0A, 6'h1A, 6'h0E, 6'h1E, 6'h2E,
                                        6'h2A, 6'h12, 6'h06, 6'h1B, 6'h08};
  localparam logic [4:0] EXPS [10] = '{5'h0A, 5'h07, 5'h0A, 5'h07, 5'h0C,
                                       5'h10, 5'h1D, 5'h1C, 5'h1C, 5'h0A};
  // =====================================================
  // clocks: parallel clock offset so the two never line up
  always #2 clock = ~clock;
  initial begin
    #1.3;
    forever #3 pclk = ~pclk;
  end
  vsim_top dut_u (.i_clock(clock), .i_arst_n(arst_n), .i_pclk(pclk),
    .i_standby(pins[0]), .i_serial_output_enable(pins[1]), .i_rate_select(pins[2]),
    .i_bus_width_select(pins[3]), .i_standard_processing_enable(pins[4]),
    .i_async_serial_iface_mode(pins[5]), .i_din(din), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_upper_data(up_data), .o_upper_valid(up_valid),
    .o_upper_route(route), .o_scramble_en(scr_en), .o_rate_sd(rate_sd),
    .o_standby(standby), .o_sdo_p(sdo_p), .o_sdo_n(sdo_n), .o_sdo_oe(sdo_oe));
  vsim_source src_u (.i_pclk(pclk), .i_arst_n(arst_n), .i_word(word),
    .i_rate_select(pins[2]), .i_bus_width_select(pins[3]),
    .i_standard_processing_enable(pins[4]), .i_async_serial_iface_mode(pins[5]),
    .i_break_rule(brk), .o_din(din));
  // =====================================================
  // shared tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, then return to zero
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge clock);
    #1;
    chk("rdata_idle", rdata, 32'h00000000);
  endtask
  // pins need two sync stages plus the output register; six edges leave margin
  task automatic settle;
    repeat (6) @(posedge pclk);
    @(posedge clock);
    #1;
  endtask
  task automatic set_mode(input logic [5:0] p, input logic [9:0] w);
    @(posedge clock);
    pins <= p;
    word <= w;
    settle();
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end
  // =====================================================
  // main sequence
  initial begin
    logic [31:0] d;
    logic [9:0] w;
    logic [4:0] e;
    logic [5:0] m;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    #1;
    chk("reset_route", route, 32'h0);
    chk("reset_rate", rate_sd, 32'h0);
    chk("reset_oe", sdo_oe, 32'h0);
    // ten mode combinations covering every route of the half-bus, data varied per row
    for (int i = 0; i < 10; i++) begin
      m = MODES[i];
      e = EXPS[i];
      w = 10'h201 + 10'(i) * 10'h07F;
      set_mode(m, w);
      if (e[4:2] != 3'h7) chk("route", route, e[4:2]);
      chk("valid", up_valid, e[1]);
      if (!e[1]) chk("data_zero", up_data, 32'h0);
      if (e[4:2] == 3'h2) chk("data_raw", up_data, w);
      if (e[4:2] == 3'h2 && m[1]) chk("sdo_p", sdo_p, ^w);
      chk("scramble", scr_en, e[0]);
      chk("rate_sd", rate_sd, m[2]);
      chk("standby", standby, m[0]);
      if (!m[0]) chk("sdo_oe", sdo_oe, m[1]);
      if (sdo_oe === 1'b1) chk("sdo_n", sdo_n, !sdo_p);
      reg_rd(VSIM_ADDR_STATUS, d);
      chk("status", d & 32'hFFFFFFBF, {24'h0, m[5] && (!m[2] || m[4]), 1'b0, m});
    end
    // a source that breaks the all-low duty in async mode leaves a sticky mark
    @(posedge clock);
    brk <= 1'b1;
    set_mode(6'h2E, 10'h155);
    chk("asi_route", route, 32'h3);
    chk("asi_data", up_data, 32'h0);
    @(posedge clock);
    brk <= 1'b0;
    settle();
    reg_rd(VSIM_ADDR_STATUS, d);
    chk("asi_sticky", d, 32'h0000006E);
    // soft standby and soft serial off through the control word
    set_mode(6'h0A, 10'h3C5);
    reg_wr(VSIM_ADDR_CTRL, 32'hFFFFFFFF);
    settle();
    chk("soft_standby", standby, 32'h1);
    chk("soft_valid", up_valid, 32'h0);
    chk("soft_oe", sdo_oe, 32'h0);
    reg_rd(VSIM_ADDR_CTRL, d);
    chk("ctrl_read", d, 32'h00000003);
    reg_wr(VSIM_ADDR_CTRL, 32'h00000000);
    settle();
    chk("oe_back", sdo_oe, 32'h1);
    chk("data_back", up_data, 32'h3C5);
    // sticky flag clears on a one, no new event in raw mode
    reg_wr(VSIM_ADDR_STATUS, 32'h00000040);
    reg_rd(VSIM_ADDR_STATUS, d);
    chk("sticky_clear", d, 32'h0000000A);
    // unmapped indices read zero and ignore writes
    reg_wr(4'hF, 32'hFFFFFFFF);
    reg_rd(4'hF, d);
    chk("unmapped_f", d, 32'h0);
    reg_rd(4'h7, d);
    chk("unmapped_7", d, 32'h0);
    reg_rd(VSIM_ADDR_CTRL, d);
    chk("ctrl_kept", d, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
